// >>> src/flk_pkg.sv
// shared constants, types and state layout of the flash key-lock sequencer
package flk_pkg;

	// ****************************************
	// key codes and control bits
	// ****************************************
	localparam logic [7:0]  KEY_FIRST_CODE  = 8'ha5;
	localparam logic [7:0]  KEY_SECOND_CODE = 8'hf1;
	localparam int          CTL_WE_BIT      = 0;
	localparam int          CTL_EE_BIT      = 1;

	// ****************************************
	// memory geometry
	// ****************************************
	localparam int          NVM_AW          = 14;
	localparam int          XD_AW           = 16;
	localparam int          DW              = 8;
	localparam logic [15:0] USER_LAST_ADDR  = 16'h3dff;
	localparam logic [13:0] PAGE_MASK       = 14'h3e00;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;

	// ****************************************
	// timing
	// ****************************************
	localparam int          CLK_PERIOD_NS   = 40;
	localparam int          WRITE_TIME_NS   = 55000;
	localparam int          ERASE_TIME_MS   = 15;
	localparam int          WRITE_CYC       = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int          ERASE_CYC       = (ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int          TMR_W           = 20;

	// ****************************************
	// state machines
	// ****************************************
	typedef enum logic [3:0] {
		KEY_IDLE   = 4'h1,
		KEY_SEEN   = 4'h2,
		KEY_ARMED  = 4'h4,
		KEY_LOCKED = 4'h8
	} flk_key_e;

	typedef enum logic [2:0] {
		OP_IDLE  = 3'h1,
		OP_FETCH = 3'h2,
		OP_RUN   = 3'h4
	} flk_op_e;

	typedef struct packed {
		flk_key_e          key;
		flk_op_e           op;
		logic              program_store_write_enable;
		logic              program_store_erase_enable;
		logic              isErase;
		logic              swOp;
		logic [NVM_AW-1:0] addr;
		logic [DW-1:0]     data;
		logic              nvmRd;
		logic              nvmPgm;
		logic              nvmErs;
		logic [DW-1:0]     nvmWd;
		logic              stall;
		logic              ramWr;
		logic              ramRd;
		logic [XD_AW-1:0]  ramAddr;
		logic [DW-1:0]     ramWd;
		logic              codePend;
		logic              codeVld;
		logic [DW-1:0]     codeData;
		logic              errRst;
		logic              errFlag;
		logic              tmrStart;
		logic [TMR_W-1:0]  tmrLoad;
	} flk_state_s;

	typedef struct packed {
		logic             busy;
		logic [TMR_W-1:0] cnt;
		logic             done;
	} flk_tmr_s;

endpackage : flk_pkg

// >>> src/flk_tmr_if.sv
// carrier between the sequencer and its operation timer
`timescale 1ns/10ps
interface flk_tmr_if;
	import flk_pkg::*;
	logic             start;
	logic [TMR_W-1:0] load;
	logic             done;

	modport ctrl  (output start, output load, input done);
	modport timer (input start, input load, output done);
endinterface : flk_tmr_if

// >>> src/flk_timer.sv
// self-timing counter for program and erase operations
`timescale 1ns/10ps
module flk_timer
	import flk_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// control carrier
	flk_tmr_if.timer t
);

	flk_tmr_s st_r;
	flk_tmr_s st_nxt;

	// ****************************************
	// countdown
	// ****************************************
	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		if (t.start) begin
			st_nxt.busy = 1'b1;
			st_nxt.cnt  = t.load;
		end else if (st_r.busy) begin
			if (st_r.cnt <= TMR_W'(1)) begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
				st_nxt.cnt  = '0;
			end else begin
				st_nxt.cnt = st_r.cnt - TMR_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign t.done = st_r.done;

endmodule : flk_timer

// >>> src/flk_ctrl.sv
// flash program/erase sequencer with key lock, top module
`timescale 1ns/10ps
module flk_ctrl
	import flk_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_CYC
)
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	// processor special registers
	input  wire logic              keyWr,
	input  wire logic [DW-1:0]     keyData,
	input  wire logic              ctlWr,
	input  wire logic [DW-1:0]     ctlData,
	output      logic [1:0]        ctlState,
	// processor external-data moves
	input  wire logic              xdWr,
	input  wire logic              xdRd,
	input  wire logic [XD_AW-1:0]  xdAddr,
	input  wire logic [DW-1:0]     xdWrData,
	// processor code-space reads
	input  wire logic              codeRd,
	input  wire logic [XD_AW-1:0]  codeAddr,
	output      logic              codeRdValid,
	output      logic [DW-1:0]     codeRdData,
	output      logic              cpuStall,
	// two-wire debug port operations
	input  wire logic              dbgProg,
	input  wire logic              dbgErase,
	input  wire logic [XD_AW-1:0]  dbgAddr,
	input  wire logic [DW-1:0]     dbgData,
	// supply monitor status
	input  wire logic              supMonOn,
	input  wire logic              supMonRstSel,
	// error reset
	input  wire logic              errFlagClr,
	output      logic              memErrRst,
	output      logic              memErrFlag,
	// data RAM port
	output      logic              ramWrEn,
	output      logic              ramRdEn,
	output      logic [XD_AW-1:0]  ramAddr,
	output      logic [DW-1:0]     ramWrData,
	// flash array port
	output      logic              nvmRdEn,
	output      logic              nvmProgram,
	output      logic              nvmErase,
	output      logic [NVM_AW-1:0] nvmAddr,
	output      logic [DW-1:0]     nvmWrData,
	input  wire logic [DW-1:0]     nvmRdData,
	// key status
	output      logic              keyLocked
);

	flk_state_s st_r;
	flk_state_s st_nxt;
	flk_tmr_if  tmr ();

	logic swAddrBad;
	logic codeAddrBad;
	logic dbgAddrBad;
	logic supplyBad;
	logic swFlashWr;
	logic opIdle;

	// ****************************************
	// operation timer
	// ****************************************
	flk_timer u_timer (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.t       (tmr)
	);

	assign tmr.start = st_r.tmrStart;
	assign tmr.load  = st_r.tmrLoad;

	// ****************************************
	// request qualification
	// ****************************************
	assign swAddrBad   = (xdAddr > USER_LAST_ADDR);
	assign codeAddrBad = (codeAddr > USER_LAST_ADDR);
	assign dbgAddrBad  = (dbgAddr > USER_LAST_ADDR);
	assign supplyBad   = !supMonOn || !supMonRstSel;
	assign swFlashWr   = xdWr && st_r.program_store_write_enable;
	assign opIdle      = (st_r.op == OP_IDLE);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_nxt          = st_r;
		st_nxt.ramWr    = 1'b0;
		st_nxt.ramRd    = 1'b0;
		st_nxt.nvmRd    = 1'b0;
		st_nxt.codeVld  = 1'b0;
		st_nxt.codePend = 1'b0;
		st_nxt.errRst   = 1'b0;
		st_nxt.tmrStart = 1'b0;

		// control register, held until software rewrites it
		if (ctlWr && opIdle) begin
			st_nxt.program_store_write_enable = ctlData[CTL_WE_BIT];
			st_nxt.program_store_erase_enable = ctlData[CTL_EE_BIT];
		end

		// key sequence, order and value only
		if (keyWr && opIdle) begin
			case (st_r.key)
				KEY_IDLE: begin
					st_nxt.key = (keyData == KEY_FIRST_CODE) ? KEY_SEEN : KEY_LOCKED;
				end
				KEY_SEEN: begin
					st_nxt.key = (keyData == KEY_SECOND_CODE) ? KEY_ARMED : KEY_LOCKED;
				end
				KEY_ARMED: begin
					st_nxt.key = KEY_LOCKED;
				end
				KEY_LOCKED: begin
					st_nxt.key = KEY_LOCKED;
				end
				default: begin
					st_nxt.key = KEY_LOCKED;
				end
			endcase
		end

		// data RAM path: reads when idle, writes when idle and not redirected
		if (xdRd && opIdle) begin
			st_nxt.ramRd   = 1'b1;
			st_nxt.ramAddr = xdAddr;
		end
		if (xdWr && !st_r.program_store_write_enable && opIdle) begin
			st_nxt.ramWr   = 1'b1;
			st_nxt.ramAddr = xdAddr;
			st_nxt.ramWd   = xdWrData;
		end

		case (st_r.op)
			OP_IDLE: begin
				if (swFlashWr) begin
					if (swAddrBad || supplyBad) begin
						st_nxt.errRst = 1'b1;
					end else if (st_r.key == KEY_ARMED) begin
						st_nxt.op      = OP_FETCH;
						st_nxt.swOp    = 1'b1;
						st_nxt.isErase = st_r.program_store_erase_enable;
						st_nxt.addr    = xdAddr[NVM_AW-1:0];
						st_nxt.data    = xdWrData;
						st_nxt.nvmRd   = 1'b1;
						st_nxt.stall   = 1'b1;
					end else if (st_r.key != KEY_LOCKED) begin
						st_nxt.key = KEY_LOCKED;
					end
				end else if ((dbgProg || dbgErase) && !dbgAddrBad) begin
					st_nxt.op      = OP_FETCH;
					st_nxt.swOp    = 1'b0;
					st_nxt.isErase = dbgErase;
					st_nxt.addr    = dbgAddr[NVM_AW-1:0];
					st_nxt.data    = dbgData;
					st_nxt.nvmRd   = 1'b1;
					st_nxt.stall   = 1'b1;
				end else if (codeRd) begin
					if (codeAddrBad) begin
						st_nxt.errRst = 1'b1;
					end else begin
						st_nxt.nvmRd    = 1'b1;
						st_nxt.addr     = codeAddr[NVM_AW-1:0];
						st_nxt.codePend = 1'b1;
					end
				end
				if (st_r.codePend) begin
					st_nxt.codeVld  = 1'b1;
					st_nxt.codeData = nvmRdData;
				end
			end
			OP_FETCH: begin
				st_nxt.op       = OP_RUN;
				st_nxt.tmrStart = 1'b1;
				if (st_r.isErase) begin
					st_nxt.nvmErs  = 1'b1;
					st_nxt.addr    = st_r.addr & PAGE_MASK;
					st_nxt.nvmWd   = ERASED_BYTE;
					st_nxt.tmrLoad = TMR_W'(ERASE_CYCLES);
				end else begin
					st_nxt.nvmPgm  = 1'b1;
					st_nxt.nvmWd   = st_r.data & nvmRdData;
					st_nxt.tmrLoad = TMR_W'(WRITE_CYC);
				end
			end
			OP_RUN: begin
				if (tmr.done) begin
					st_nxt.op     = OP_IDLE;
					st_nxt.nvmPgm = 1'b0;
					st_nxt.nvmErs = 1'b0;
					st_nxt.stall  = 1'b0;
					if (st_r.swOp && st_r.key == KEY_ARMED) begin
						st_nxt.key = KEY_IDLE;
					end
				end
			end
			default: begin
				st_nxt.op = OP_IDLE;
			end
		endcase

		// error flag, set wins over clear
		if (errFlagClr) begin
			st_nxt.errFlag = 1'b0;
		end
		if (st_nxt.errRst) begin
			st_nxt.errFlag = 1'b1;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_r     <= '0;
			st_r.key <= KEY_IDLE;
			st_r.op  <= OP_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign ctlState    = {st_r.program_store_erase_enable, st_r.program_store_write_enable};
	assign codeRdValid = st_r.codeVld;
	assign codeRdData  = st_r.codeData;
	assign cpuStall    = st_r.stall;
	assign memErrRst   = st_r.errRst;
	assign memErrFlag  = st_r.errFlag;
	assign ramWrEn     = st_r.ramWr;
	assign ramRdEn     = st_r.ramRd;
	assign ramAddr     = st_r.ramAddr;
	assign ramWrData   = st_r.ramWd;
	assign nvmRdEn     = st_r.nvmRd;
	assign nvmProgram  = st_r.nvmPgm;
	assign nvmErase    = st_r.nvmErs;
	assign nvmAddr     = st_r.addr;
	assign nvmWrData   = st_r.nvmWd;
	assign keyLocked   = st_r.key[3];

	// ****************************************
	// assertions
	// ****************************************
	property p_prog_and;
		@(posedge clk_sys) disable iff (!rstn)
		(st_r.op == OP_FETCH && !st_r.isErase) |=>
			(nvmProgram && nvmWrData == ($past(nvmRdData) & $past(st_r.data)));
	endproperty
	a_prog_and: assert property (p_prog_and) else $error("program value not ANDed");

	property p_erase_page;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(nvmErase) |-> (nvmAddr == (nvmAddr & PAGE_MASK)) && nvmWrData == ERASED_BYTE;
	endproperty
	a_erase_page: assert property (p_erase_page) else $error("erase not page aligned");

	property p_stall;
		@(posedge clk_sys) disable iff (!rstn)
		(st_r.op != OP_IDLE) |-> cpuStall;
	endproperty
	a_stall: assert property (p_stall) else $error("stall missing during operation");

	property p_lock_sticky;
		@(posedge clk_sys) disable iff (!rstn)
		keyLocked |=> keyLocked [*3];
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock released");

	property p_early_attempt;
		@(posedge clk_sys) disable iff (!rstn)
		(swFlashWr && opIdle && !swAddrBad && !supplyBad &&
		 (st_r.key == KEY_IDLE || st_r.key == KEY_SEEN)) |=> keyLocked && !nvmRdEn;
	endproperty
	a_early_attempt: assert property (p_early_attempt) else $error("early attempt not locked");

	property p_relock;
		@(posedge clk_sys) disable iff (!rstn)
		(st_r.op == OP_RUN && tmr.done && st_r.swOp) |=> st_r.key != KEY_ARMED && !cpuStall;
	endproperty
	a_relock: assert property (p_relock) else $error("not relocked after operation");

	property p_key_pair;
		@(posedge clk_sys) disable iff (!rstn)
		(st_r.key == KEY_SEEN && keyWr && opIdle && keyData == KEY_SECOND_CODE) |=>
			st_r.key == KEY_ARMED;
	endproperty
	a_key_pair: assert property (p_key_pair) else $error("second key not accepted");

	property p_ram_write;
		@(posedge clk_sys) disable iff (!rstn)
		(xdWr && !st_r.program_store_write_enable && opIdle) |=> ramWrEn && ramAddr == $past(xdAddr);
	endproperty
	a_ram_write: assert property (p_ram_write) else $error("ram write lost");

	property p_ram_read;
		@(posedge clk_sys) disable iff (!rstn)
		(xdRd && opIdle) |=> ramRdEn && !nvmProgram && !nvmErase;
	endproperty
	a_ram_read: assert property (p_ram_read) else $error("external read not to ram");

	property p_bad_addr;
		@(posedge clk_sys) disable iff (!rstn)
		(swFlashWr && opIdle && swAddrBad) |=> memErrRst && memErrFlag;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("no error reset on bad address");

	property p_erase_enables;
		@(posedge clk_sys) disable iff (!rstn)
		(swFlashWr && opIdle && st_r.key == KEY_ARMED && !swAddrBad && !supplyBad) |=>
			(st_r.isErase == $past(st_r.program_store_erase_enable)) ##1 (nvmErase == st_r.isErase);
	endproperty
	a_erase_enables: assert property (p_erase_enables) else $error("erase enable ignored");

	// program length counter, checked when the strobe drops
	localparam int PGM_MIN_CYC = 40000 / CLK_PERIOD_NS;
	localparam int PGM_MAX_CYC = 70000 / CLK_PERIOD_NS;

	logic [TMR_W-1:0] pgmLen_r;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pgmLen_r <= '0;
		end else if (nvmProgram) begin
			pgmLen_r <= pgmLen_r + TMR_W'(1);
		end else begin
			pgmLen_r <= '0;
		end
	end

	property p_prog_time;
		@(posedge clk_sys) disable iff (!rstn)
		$fell(nvmProgram) |-> (pgmLen_r >= TMR_W'(PGM_MIN_CYC)) &&
			(pgmLen_r <= TMR_W'(PGM_MAX_CYC));
	endproperty
	a_prog_time: assert property (p_prog_time) else $error("program time out of range");

endmodule : flk_ctrl

// >>> verif/flk_nvm_model.sv
// flash array model behind the sequencer
`timescale 1ns/10ps
module flk_nvm_model
	import flk_pkg::*;
(
	// clock
	input  wire logic              clk_sys,
	// array port
	input  wire logic              nvmRdEn,
	input  wire logic              nvmProgram,
	input  wire logic              nvmErase,
	input  wire logic [NVM_AW-1:0] nvmAddr,
	input  wire logic [DW-1:0]     nvmWrData,
	output      logic [DW-1:0]     nvmRdData
);
	logic [DW-1:0]     mem [0:16383];
	logic [NVM_AW-1:0] addr_r;
	logic [DW-1:0]     wd_r;
	logic [DW-1:0]     rd_r;
	logic [DW-1:0]     junk_r = 8'h5a;
	logic              hold_r = 1'b0;
	logic              prg_r  = 1'b0;
	logic              ers_r  = 1'b0;

	initial for (int i = 0; i < 16384; i++) mem[i] = ERASED_BYTE;

	// data valid with the strobe and one cycle after, junk otherwise
	assign nvmRdData = nvmRdEn ? mem[nvmAddr] : (hold_r ? rd_r : junk_r);

	always @(posedge clk_sys) begin
		junk_r <= ~junk_r;
		hold_r <= nvmRdEn;
		prg_r  <= nvmProgram;
		ers_r  <= nvmErase;
		if (nvmRdEn)
			rd_r <= mem[nvmAddr];
		if (nvmProgram | nvmErase) begin
			addr_r <= nvmAddr;
			wd_r   <= nvmWrData;
		end
		if (prg_r & !nvmProgram)
			mem[addr_r] <= wd_r;
		if (ers_r & !nvmErase)
			for (int i = 0; i < 512; i++)
				mem[{addr_r[13:9], i[8:0]}] <= ERASED_BYTE;
	end
endmodule : flk_nvm_model

// >>> verif/flk_ctrl_bench.sv
// self-checking bench of the flash key-lock sequencer
`timescale 1ns/10ps
module flk_ctrl_bench
	import flk_pkg::*;
;
	// ****
	// signals
	// ****
	logic                clk_sys = 1'b0;
	logic                rstn, keyWr, ctlWr, xdWr, xdRd, codeRd, dbgProg, dbgErase;
	logic                supMonOn, supMonRstSel, errFlagClr, codeRdValid, cpuStall;
	logic                memErrRst, memErrFlag, ramWrEn, ramRdEn, nvmRdEn, keyLocked;
	logic                nvmProgram, nvmErase;
	logic [1:0]          ctlState;
	logic [DW-1:0]       keyData, ctlData, xdWrData, dbgData, codeRdData;
	logic [DW-1:0]       ramWrData, nvmWrData, nvmRdData;
	logic [XD_AW-1:0]    xdAddr, codeAddr, dbgAddr, ramAddr;
	logic [NVM_AW-1:0]   nvmAddr;
	int                  n_fail = 0;
	int                  n_compared = 0;

	initial forever #20 clk_sys = ~clk_sys;

	flk_ctrl #(.ERASE_CYCLES(40)) flk_ctrl_inst (.clk_sys, .rstn, .keyWr, .keyData,
		.ctlWr, .ctlData, .ctlState, .xdWr, .xdRd, .xdAddr, .xdWrData, .codeRd,
		.codeAddr, .codeRdValid, .codeRdData, .cpuStall, .dbgProg, .dbgErase, .dbgAddr,
		.dbgData, .supMonOn, .supMonRstSel, .errFlagClr, .memErrRst, .memErrFlag,
		.ramWrEn, .ramRdEn, .ramAddr, .ramWrData, .nvmRdEn, .nvmProgram, .nvmErase,
		.nvmAddr, .nvmWrData, .nvmRdData, .keyLocked);

	flk_nvm_model flk_nvm_model_inst (.clk_sys, .nvmRdEn, .nvmProgram, .nvmErase,
		.nvmAddr, .nvmWrData, .nvmRdData);

	// ****
	// tasks
	// ****
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic rst;
		rstn = 1'b0;
		tick(3);
		rstn = 1'b1;
		tick(1);
	endtask : rst

	task automatic key(input logic [7:0] d);
		keyWr = 1'b1;
		keyData = d;
		tick(1);
		keyWr = 1'b0;
	endtask : key

	task automatic keys;
		keyWr = 1'b1;
		keyData = KEY_FIRST_CODE;
		tick(1);
		keyData = KEY_SECOND_CODE;
		tick(1);
		keyWr = 1'b0;
	endtask : keys

	task automatic ctl(input logic [7:0] d);
		ctlWr = 1'b1;
		ctlData = d;
		tick(1);
		ctlWr = 1'b0;
	endtask : ctl

	task automatic xdw(input logic [15:0] a, input logic [7:0] d);
		xdWr = 1'b1;
		xdAddr = a;
		xdWrData = d;
		tick(1);
		xdWr = 1'b0;
	endtask : xdw

	task automatic waitOp(output int len);
		len = 0;
		for (int i = 0; i < 4 && cpuStall !== 1'b1; i++) tick(1);
		while (cpuStall === 1'b1 && len < 3000) begin
			len++;
			tick(1);
		end
		tick(2);
	endtask : waitOp

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		codeRd = 1'b1;
		codeAddr = a;
		tick(1);
		codeRd = 1'b0;
		for (int i = 0; i < 5 && codeRdValid !== 1'b1; i++) tick(1);
		d = codeRdData;
	endtask : rd

	task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
		output int len);
		keys();
		ctl(c);
		xdw(a, d);
		waitOp(len);
	endtask : op

	// ****
	// tests
	// ****
	task automatic t_program;
		int         len;
		logic [7:0] v;
		op(8'h01, 16'h0201, 8'h5a, len);
		check(len >= 1000 && len <= 1750, 1'b1);
		check(ctlState, 2'b01);
		rd(16'h0201, v);
		check(v, 8'h5a);
		key(KEY_FIRST_CODE);
		tick(60);
		key(KEY_SECOND_CODE);
		xdw(16'h0201, 8'ha5);
		check(cpuStall, 1'b1);
		waitOp(len);
		check(keyLocked, 1'b0);
		rd(16'h0201, v);
		check(v, 8'h00);
		$display("program test done");
	endtask : t_program

	task automatic t_erase;
		int         len;
		logic [7:0] v;
		keys();
		ctl(8'h03);
		xdw(16'h03aa, 8'h12);
		for (int i = 0; i < 4 && nvmErase !== 1'b1; i++) tick(1);
		check(nvmAddr, 14'h0200);
		check(cpuStall, 1'b1);
		waitOp(len);
		check(len >= 40, 1'b1);
		rd(16'h0201, v);
		check(v, ERASED_BYTE);
		ctl(8'h00);
		$display("erase test done");
	endtask : t_erase

	task automatic t_ram;
		ctl(8'h02);
		xdw(16'h1234, 8'h77);
		check(ramWrEn, 1'b1);
		check(ramAddr, 16'h1234);
		check(ramWrData, 8'h77);
		check(cpuStall, 1'b0);
		ctl(8'h01);
		xdRd = 1'b1;
		xdAddr = 16'h0201;
		tick(1);
		xdRd = 1'b0;
		check(ramRdEn, 1'b1);
		check(nvmRdEn, 1'b0);
		ctl(8'h00);
		$display("ram test done");
	endtask : t_ram

	task automatic t_error;
		keys();
		ctl(8'h01);
		xdw(16'h3e00, 8'h00);
		check(memErrRst, 1'b1);
		check(cpuStall, 1'b0);
		tick(1);
		check(memErrFlag, 1'b1);
		errFlagClr = 1'b1;
		tick(1);
		errFlagClr = 1'b0;
		check(memErrFlag, 1'b0);
		supMonOn = 1'b0;
		xdw(16'h0100, 8'h00);
		check(memErrRst, 1'b1);
		supMonOn = 1'b1;
		supMonRstSel = 1'b0;
		tick(1);
		xdw(16'h0100, 8'h00);
		check(memErrRst, 1'b1);
		supMonRstSel = 1'b1;
		rst();
		$display("error test done");
	endtask : t_error

	task automatic t_lock;
		int         len;
		logic [7:0] v;
		key(KEY_FIRST_CODE);
		tick(1);
		key(8'h00);
		check(keyLocked, 1'b1);
		op(8'h01, 16'h0100, 8'h00, len);
		check(len, 0);
		dbgProg = 1'b1;
		dbgAddr = 16'h0300;
		dbgData = 8'h3c;
		tick(1);
		dbgProg = 1'b0;
		waitOp(len);
		rd(16'h0300, v);
		check(v, 8'h3c);
		dbgErase = 1'b1;
		tick(1);
		dbgErase = 1'b0;
		waitOp(len);
		rd(16'h0300, v);
		check(v, ERASED_BYTE);
		check(keyLocked, 1'b1);
		rst();
		check(keyLocked, 1'b0);
		key(KEY_SECOND_CODE);
		tick(1);
		key(KEY_FIRST_CODE);
		check(keyLocked, 1'b1);
		rst();
		ctl(8'h01);
		xdw(16'h0100, 8'h00);
		check(keyLocked, 1'b1);
		rst();
		op(8'h01, 16'h0102, 8'h0f, len);
		xdw(16'h0102, 8'h00);
		check(cpuStall, 1'b0);
		check(keyLocked, 1'b1);
		rd(16'h0102, v);
		check(v, 8'h0f);
		$display("lock test done");
	endtask : t_lock

	// ****
	// main sequence and watchdog
	// ****
	initial begin
		{keyWr, ctlWr, xdWr, xdRd, codeRd, dbgProg, dbgErase, errFlagClr} = '0;
		{keyData, ctlData, xdWrData, dbgData} = '0;
		{xdAddr, codeAddr, dbgAddr} = '0;
		supMonOn = 1'b1;
		supMonRstSel = 1'b1;
		rst();
		t_program();
		t_erase();
		t_ram();
		t_error();
		t_lock();
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		wrap_up();
	end
endmodule : flk_ctrl_bench
